/* charger_thermal_status_map.vh */
`ifndef CHARGER_THERMAL_STATUS_MAP_VH
`define CHARGER_THERMAL_STATUS_MAP_VH

// register offsets
`define THERM_CFG_OFFSET 8'h18
`define ILIM_OFFSET 8'h19
`define FLAGS_OFFSET 8'h1B

// reset values
`define THERM_CFG_RESET 8'h54
`define ILIM_RESET 9'h000
`define FLAGS_RESET 8'h00

// thermistor configuration fields
`define COOL_SEL_MSB 7
`define COOL_SEL_LSB 6
`define WARM_SEL_MSB 5
`define WARM_SEL_LSB 4
`define HOT_SEL_MSB 3
`define HOT_SEL_LSB 2
`define COLD_SEL_BIT 1
`define BYPASS_BIT 0
`define HOT_SEL_DISABLE 2'h3

// status flag positions
`define FLAG_CURRENT_REG 7
`define FLAG_VOLTAGE_REG 6
`define FLAG_WATCHDOG 5
`define FLAG_POWER_GOOD 3
`define FLAG_SECOND_IN 2
`define FLAG_FIRST_IN 1
`define FLAG_BUS_IN 0

// current limit field, 10 mA per code
`define ILIM_WIDTH 9
`define ILIM_STEP_MA 10
`define ILIM_MIN_MA 100
`define ILIM_MIN_CODE 9'h00A

// cool threshold, tenths of a percent of the regulator voltage
`define COOL_PM_0 10'h2C7
`define COOL_PM_1 10'h2AC
`define COOL_PM_2 10'h28F
`define COOL_PM_3 10'h270
// warm threshold, tenths of a percent
`define WARM_PM_0 10'h1E4
`define WARM_PM_1 10'h1C0
`define WARM_PM_2 10'h19C
`define WARM_PM_3 10'h179
// otg limits, degrees celsius, two's complement
`define OTG_HOT_C_0 8'h37
`define OTG_HOT_C_1 8'h3C
`define OTG_HOT_C_2 8'h41
`define OTG_COLD_C_0 8'hF6
`define OTG_COLD_C_1 8'hEC

`endif

/* pin_sync3.v */
`timescale 1ns/1ns
`include "charger_thermal_status_map.vh"

// three-stage synchroniser; output moves once stages two and three agree
module pin_sync3 #(
  parameter WIDTH = 13
) (
  // clock and reset
  input wire clk_i,
  input wire nrst_i,
  // pins and clean levels
  input wire [WIDTH-1:0] pin_i,
  output wire [WIDTH-1:0] level_o
);

  reg [WIDTH-1:0] s1_r;
  reg [WIDTH-1:0] s2_r;
  reg [WIDTH-1:0] s3_r;
  reg [WIDTH-1:0] level_r;

  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1)
    begin : g_bit
      // per-bit chain; first stage feeds only the second
      always @(posedge clk_i)
      begin
        if (!nrst_i)
        begin
          s1_r[i] <= 1'b0;
          s2_r[i] <= 1'b0;
          s3_r[i] <= 1'b0;
          level_r[i] <= 1'b0;
        end
        else
        begin
          s1_r[i] <= pin_i[i];
          s2_r[i] <= s1_r[i];
          s3_r[i] <= s2_r[i];
          if (s2_r[i] == s3_r[i])
            level_r[i] <= s3_r[i];
        end
      end
    end
  endgenerate

  assign level_o = level_r;

endmodule // pin_sync3

/* charger_thermal_status_regs.v */
`timescale 1ns/1ns
`include "charger_thermal_status_map.vh"

// Summary of operation
// - bits 7:6 pick the rising cool threshold 71.1/68.4/65.5/62.4 percent, code 1 after reset.
// - bits 5:4 pick the falling warm threshold 48.4/44.8/41.2/37.7 percent, code 1 after reset.
// - bits 3:2 pick the otg hot limit 55/60/65 degrees, code 3 turns the hot check off, code 1 at reset.
// - bit 1 picks the otg cold limit, 0 for minus ten and 1 for minus twenty degrees, 0 at reset.
// - bit 0 makes the thermistor always good so charging and otg run whatever the comparators say.
// - while the thermistor is bypassed all four thermistor status bits read 0000.
// - the configuration register at 18h resets to 54h and also on register reset or watchdog expiry.
// - register 19h bits 8:0 give the input current limit in 10 mA steps, clamped low at 100 mA, reset 0.
// - status bit 7 shows input current regulation in forward mode or output current regulation in otg.
// - status bit 6 shows input voltage regulation in forward mode or output voltage regulation in otg.
// - status bit 5 is set while the host-bus watchdog has expired.
// - status bit 3 shows power good.
// - status bit 2 shows the second input above its present threshold.
// - status bit 1 shows the first input above its present threshold.
// - status bit 0 shows the bus input above its present threshold.
module charger_thermal_status_regs (
  // clock and reset
  input wire clk_i,
  input wire nrst_i,
  // register access from the host-bus engine
  input wire [7:0] reg_addr_i,
  input wire reg_wr_i,
  input wire [7:0] reg_wdata_i,
  input wire reg_rd_i,
  output reg [15:0] reg_rdata_o,
  output reg reg_rd_ack_o,
  // reset sources from the same clock domain
  input wire reg_reset_i,
  input wire watchdog_expired_i,
  // operating mode and current limit source, same clock domain
  input wire otg_mode_i,
  input wire ilim_load_i,
  input wire [8:0] optimized_current_limit_i,
  // analog comparator levels, asynchronous
  input wire input_current_reg_i,
  input wire output_current_reg_i,
  input wire input_voltage_reg_i,
  input wire output_voltage_reg_i,
  input wire power_good_i,
  input wire second_input_present_i,
  input wire first_input_present_i,
  input wire bus_input_present_i,
  input wire [3:0] ts_comparator_i,
  // configuration fields
  output wire [1:0] cool_threshold_sel_o,
  output wire [1:0] warm_threshold_sel_o,
  output wire [1:0] otg_hot_limit_sel_o,
  output wire otg_cold_limit_sel_o,
  output wire thermistor_bypass_o,
  // decoded thresholds
  output reg [9:0] cool_threshold_permille_o,
  output reg [9:0] warm_threshold_permille_o,
  output reg [7:0] otg_hot_limit_c_o,
  output reg otg_hot_check_en_o,
  output reg [7:0] otg_cold_limit_c_o,
  // thermistor verdicts
  output reg [3:0] ts_status_o,
  output reg charge_temp_ok_o,
  output reg otg_temp_ok_o,
  // current limit and status values
  output wire [8:0] optimized_current_limit_o,
  output wire [7:0] charger_condition_flags_o
);

  // synchroniser width: eight status levels plus four thermistor levels
  localparam SYNC_W = 12;

  ////////////////////////////////////////////////////////////////////////////////
  // synchronised comparator levels

  wire [SYNC_W-1:0] raw_pins;
  wire [SYNC_W-1:0] clean;

  // pack the asynchronous levels, regulation levels low and thermistor levels high
  assign raw_pins[0] = input_current_reg_i;
  assign raw_pins[1] = output_current_reg_i;
  assign raw_pins[2] = input_voltage_reg_i;
  assign raw_pins[3] = output_voltage_reg_i;
  assign raw_pins[4] = power_good_i;
  assign raw_pins[5] = second_input_present_i;
  assign raw_pins[6] = first_input_present_i;
  assign raw_pins[7] = bus_input_present_i;
  assign raw_pins[11:8] = ts_comparator_i;

  // one chain per level; stage one feeds stage two and nothing else
  pin_sync3 #(
    .WIDTH(SYNC_W)
  ) pin_sync3_inst (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .pin_i(raw_pins),
    .level_o(clean)
  );

  wire in_cur_reg;
  wire out_cur_reg;
  wire in_volt_reg;
  wire out_volt_reg;
  wire pg_level;
  wire second_level;
  wire first_level;
  wire bus_level;
  wire [3:0] ts_level;

  // unpack clean levels
  assign in_cur_reg = clean[0];
  assign out_cur_reg = clean[1];
  assign in_volt_reg = clean[2];
  assign out_volt_reg = clean[3];
  assign pg_level = clean[4];
  assign second_level = clean[5];
  assign first_level = clean[6];
  assign bus_level = clean[7];
  assign ts_level = clean[11:8];

  ////////////////////////////////////////////////////////////////////////////////
  // thermistor configuration register

  reg [7:0] therm_cfg_r;
  reg [7:0] therm_cfg_nxt;
  reg wd_seen_r;
  wire wd_rise;
  wire cfg_write;

  // watchdog expiry acts once, on its rising edge
  // a level held high reloads only once, so software may rewrite the fields
  assign wd_rise = watchdog_expired_i & ~wd_seen_r;
  assign cfg_write = reg_wr_i & (reg_addr_i == `THERM_CFG_OFFSET);

  // defaults win over a write in the same cycle
  // a dropped write shows as the default value on the next read
  always @*
  begin
    therm_cfg_nxt = therm_cfg_r;
    if (reg_reset_i || wd_rise)
      therm_cfg_nxt = `THERM_CFG_RESET;
    else if (cfg_write)
      therm_cfg_nxt = reg_wdata_i;
  end

  // configuration storage
  always @(posedge clk_i)
  begin
    if (!nrst_i)
    begin
      therm_cfg_r <= `THERM_CFG_RESET;
      wd_seen_r <= 1'b0;
    end
    else
    begin
      therm_cfg_r <= therm_cfg_nxt;
      wd_seen_r <= watchdog_expired_i;
    end
  end

  // field views
  assign cool_threshold_sel_o = therm_cfg_r[`COOL_SEL_MSB:`COOL_SEL_LSB];
  assign warm_threshold_sel_o = therm_cfg_r[`WARM_SEL_MSB:`WARM_SEL_LSB];
  assign otg_hot_limit_sel_o = therm_cfg_r[`HOT_SEL_MSB:`HOT_SEL_LSB];
  assign otg_cold_limit_sel_o = therm_cfg_r[`COLD_SEL_BIT];
  assign thermistor_bypass_o = therm_cfg_r[`BYPASS_BIT];

  ////////////////////////////////////////////////////////////////////////////////
  // threshold decode, registered

  wire [1:0] cool_sel_nxt;
  wire [1:0] warm_sel_nxt;
  wire [1:0] hot_sel_nxt;
  wire cold_sel_nxt;

  // decode from the next configuration value, so the decoded outputs move on
  // the same edge as the register fields and never lag a write by one cycle
  assign cool_sel_nxt = therm_cfg_nxt[`COOL_SEL_MSB:`COOL_SEL_LSB];
  assign warm_sel_nxt = therm_cfg_nxt[`WARM_SEL_MSB:`WARM_SEL_LSB];
  assign hot_sel_nxt = therm_cfg_nxt[`HOT_SEL_MSB:`HOT_SEL_LSB];
  assign cold_sel_nxt = therm_cfg_nxt[`COLD_SEL_BIT];

  // comparator thresholds in tenths of a percent of the regulator voltage
  always @(posedge clk_i)
  begin
    if (!nrst_i)
    begin
      cool_threshold_permille_o <= `COOL_PM_1;
      warm_threshold_permille_o <= `WARM_PM_1;
    end
    else
    begin
      case (cool_sel_nxt)
        2'h0: cool_threshold_permille_o <= `COOL_PM_0;
        2'h1: cool_threshold_permille_o <= `COOL_PM_1;
        2'h2: cool_threshold_permille_o <= `COOL_PM_2;
        default: cool_threshold_permille_o <= `COOL_PM_3;
      endcase
      case (warm_sel_nxt)
        2'h0: warm_threshold_permille_o <= `WARM_PM_0;
        2'h1: warm_threshold_permille_o <= `WARM_PM_1;
        2'h2: warm_threshold_permille_o <= `WARM_PM_2;
        default: warm_threshold_permille_o <= `WARM_PM_3;
      endcase
    end
  end

  // otg limits; code 3 keeps 65 degrees on the output but turns the hot check off
  always @(posedge clk_i)
  begin
    if (!nrst_i)
    begin
      otg_hot_limit_c_o <= `OTG_HOT_C_1;
      otg_hot_check_en_o <= 1'b1;
      otg_cold_limit_c_o <= `OTG_COLD_C_0;
    end
    else
    begin
      case (hot_sel_nxt)
        2'h0: otg_hot_limit_c_o <= `OTG_HOT_C_0;
        2'h1: otg_hot_limit_c_o <= `OTG_HOT_C_1;
        2'h2: otg_hot_limit_c_o <= `OTG_HOT_C_2;
        default: otg_hot_limit_c_o <= `OTG_HOT_C_2;
      endcase
      otg_hot_check_en_o <= (hot_sel_nxt != `HOT_SEL_DISABLE);
      otg_cold_limit_c_o <= cold_sel_nxt ? `OTG_COLD_C_1 : `OTG_COLD_C_0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // thermistor verdicts
  // ts bits: 3 cold, 2 cool, 1 warm, 0 hot

  wire ts_cold;
  wire ts_hot;
  wire bypass;

  assign bypass = therm_cfg_r[`BYPASS_BIT];
  assign ts_cold = ts_level[3];
  assign ts_hot = ts_level[0];

  // bypass forces normal status and allows both modes
  // verdicts use the stored register, so a bypass write shows one edge later
  always @(posedge clk_i)
  begin
    if (!nrst_i)
    begin
      ts_status_o <= 4'h0;
      charge_temp_ok_o <= 1'b0;
      otg_temp_ok_o <= 1'b0;
    end
    else
    begin
      ts_status_o <= bypass ? 4'h0 : ts_level;
      charge_temp_ok_o <= bypass | ~(ts_cold | ts_hot);
      otg_temp_ok_o <= bypass | ~(ts_cold | (ts_hot & otg_hot_check_en_o));
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // input current limit register

  reg [8:0] ilim_r;
  wire [8:0] ilim_clamped;

  // codes below the minimum read as the minimum
  // codes above the top of the range pass unchanged; only the low end is clamped
  assign ilim_clamped = (optimized_current_limit_i < `ILIM_MIN_CODE) ?
                        `ILIM_MIN_CODE : optimized_current_limit_i;

  // the register keeps its value between loads from the optimizer on ilim_load_i
  always @(posedge clk_i)
  begin
    if (!nrst_i)
      ilim_r <= `ILIM_RESET;
    else if (ilim_load_i)
      ilim_r <= ilim_clamped;
  end

  assign optimized_current_limit_o = ilim_r;

  ////////////////////////////////////////////////////////////////////////////////
  // charger condition flags, live every cycle

  reg [7:0] flags_r;
  reg [7:0] flags_nxt;

  // assemble flag byte
  // watchdog and mode come from this clock domain and skip the synchroniser
  always @*
  begin
    flags_nxt = `FLAGS_RESET;
    flags_nxt[`FLAG_CURRENT_REG] = otg_mode_i ? out_cur_reg : in_cur_reg;
    flags_nxt[`FLAG_VOLTAGE_REG] = otg_mode_i ? out_volt_reg : in_volt_reg;
    flags_nxt[`FLAG_WATCHDOG] = watchdog_expired_i;
    flags_nxt[`FLAG_POWER_GOOD] = pg_level;
    flags_nxt[`FLAG_SECOND_IN] = second_level;
    flags_nxt[`FLAG_FIRST_IN] = first_level;
    flags_nxt[`FLAG_BUS_IN] = bus_level;
  end

  // no latching; each cycle takes the present condition
  always @(posedge clk_i)
  begin
    if (!nrst_i)
      flags_r <= `FLAGS_RESET;
    else
      flags_r <= flags_nxt;
  end

  assign charger_condition_flags_o = flags_r;

  ////////////////////////////////////////////////////////////////////////////////
  // read port; one cycle latency, unmapped and reserved bits read zero

  reg [15:0] rd_mux;

  // a read and a write in one cycle return the value held before the write
  always @*
  begin
    rd_mux = 16'h0000;
    case (reg_addr_i)
      `THERM_CFG_OFFSET: rd_mux = {8'h00, therm_cfg_r};
      `ILIM_OFFSET: rd_mux = {7'h00, ilim_r};
      `FLAGS_OFFSET: rd_mux = {8'h00, flags_r};
      default: rd_mux = 16'h0000;
    endcase
  end

  // ack follows the strobe by one edge; data holds until the next read
  always @(posedge clk_i)
  begin
    if (!nrst_i)
    begin
      reg_rdata_o <= 16'h0000;
      reg_rd_ack_o <= 1'b0;
    end
    else
    begin
      reg_rd_ack_o <= reg_rd_i;
      if (reg_rd_i)
        reg_rdata_o <= rd_mux;
    end
  end

endmodule // charger_thermal_status_regs

/* charger_thermal_status_regs_checker.sv */
`timescale 1ns/1ns
`include "charger_thermal_status_map.vh"

// watches the register slice at its ports
module charger_thermal_status_regs_checker (
  // clock and reset
  input wire clk_i,
  input wire nrst_i,
  // register access and controls
  input wire [7:0] reg_addr_i,
  input wire reg_wr_i,
  input wire reg_rd_i,
  input wire [15:0] reg_rdata_o,
  input wire reg_rd_ack_o,
  input wire reg_reset_i,
  input wire watchdog_expired_i,
  input wire ilim_load_i,
  input wire [8:0] optimized_current_limit_i,
  // observed outputs
  input wire [1:0] cool_threshold_sel_o,
  input wire [1:0] warm_threshold_sel_o,
  input wire [1:0] otg_hot_limit_sel_o,
  input wire otg_cold_limit_sel_o,
  input wire thermistor_bypass_o,
  input wire otg_hot_check_en_o,
  input wire [7:0] otg_cold_limit_c_o,
  input wire [3:0] ts_status_o,
  input wire [8:0] optimized_current_limit_o,
  input wire [7:0] charger_condition_flags_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  wire [7:0] cfg = {cool_threshold_sel_o, warm_threshold_sel_o, otg_hot_limit_sel_o,
    otg_cold_limit_sel_o, thermistor_bypass_o};
  ////////////////////////////////////////////////////////////////////////////////
  // configuration back at its default value
  sequence s_cfg_default;
    cfg == `THERM_CFG_RESET;
  endsequence
  // a read of the flags register one cycle on
  sequence s_flags_answer;
    reg_rd_ack_o && reg_rdata_o == {8'h00, $past(charger_condition_flags_o)};
  endsequence
  AST_CFG_REG_RESET: assert property (reg_reset_i |=> s_cfg_default)
    else $error("config not default after register reset");
  AST_CFG_WD_RESET: assert property ($rose(watchdog_expired_i) |=> s_cfg_default)
    else $error("config not default after watchdog expiry");
  AST_RO_WRITE: assert property (reg_wr_i && reg_addr_i != `THERM_CFG_OFFSET && !reg_reset_i
    && !$rose(watchdog_expired_i) |=> $stable(cfg))
    else $error("config changed by write elsewhere");
  AST_FLAGS_READ: assert property (reg_rd_i && reg_addr_i == `FLAGS_OFFSET |=> s_flags_answer)
    else $error("flags read mismatch");
  AST_BYPASS_TS: assert property (thermistor_bypass_o |=> ts_status_o == 4'h0)
    else $error("ts status not zero while bypassed");
  AST_HOT_EN: assert property (otg_hot_check_en_o == (otg_hot_limit_sel_o != `HOT_SEL_DISABLE))
    else $error("hot check enable wrong");
  AST_COLD_C: assert property (otg_cold_limit_c_o ==
    (otg_cold_limit_sel_o ? `OTG_COLD_C_1 : `OTG_COLD_C_0))
    else $error("cold limit wrong");
  AST_ILIM_LOAD: assert property (ilim_load_i |=> optimized_current_limit_o ==
    ($past(optimized_current_limit_i) < `ILIM_MIN_CODE ? `ILIM_MIN_CODE
    : $past(optimized_current_limit_i)))
    else $error("current limit load wrong");
  AST_WD_FLAG: assert property (##1 charger_condition_flags_o[`FLAG_WATCHDOG] ==
    $past(watchdog_expired_i))
    else $error("watchdog flag wrong");
endmodule // charger_thermal_status_regs_checker

bind charger_thermal_status_regs charger_thermal_status_regs_checker checker_inst (.clk_i,
  .nrst_i, .reg_addr_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .reg_rd_ack_o, .reg_reset_i,
  .watchdog_expired_i, .ilim_load_i, .optimized_current_limit_i, .cool_threshold_sel_o,
  .warm_threshold_sel_o, .otg_hot_limit_sel_o, .otg_cold_limit_sel_o, .thermistor_bypass_o,
  .otg_hot_check_en_o, .otg_cold_limit_c_o, .ts_status_o, .optimized_current_limit_o,
  .charger_condition_flags_o);

/* charger_thermal_status_regs_bench.sv */
`timescale 1ns/1ns
`include "charger_thermal_status_map.vh"

module charger_thermal_status_regs_bench;
  logic clk_i = 0, nrst_i = 0, reg_wr_i = 0, reg_rd_i = 0, reg_reset_i = 0;
  logic watchdog_expired_i = 0, otg_mode_i = 0, ilim_load_i = 0;
  logic [7:0] reg_addr_i = 0, reg_wdata_i = 0, st = 0;
  logic [8:0] optimized_current_limit_i = 0;
  logic [3:0] ts_comparator_i = 0;
  wire [15:0] reg_rdata_o;
  wire reg_rd_ack_o, otg_cold_limit_sel_o, thermistor_bypass_o, charge_temp_ok_o;
  wire [1:0] cool_threshold_sel_o, warm_threshold_sel_o, otg_hot_limit_sel_o;
  wire [9:0] cool_threshold_permille_o, warm_threshold_permille_o;
  wire [7:0] otg_hot_limit_c_o, charger_condition_flags_o;
  wire [3:0] ts_status_o;
  wire otg_temp_ok_o;
  wire [8:0] optimized_current_limit_o;
  int error_cnt = 0, checked = 0;
  ////////////////////////////////////////////////////////////////////////////////
  // clock and device
  always #2 clk_i = ~clk_i;
  charger_thermal_status_regs charger_thermal_status_regs_inst (.clk_i, .nrst_i, .reg_addr_i,
    .reg_wr_i, .reg_wdata_i, .reg_rd_i, .reg_rdata_o, .reg_rd_ack_o, .reg_reset_i,
    .watchdog_expired_i, .otg_mode_i, .ilim_load_i, .optimized_current_limit_i,
    .input_current_reg_i(st[7]), .output_current_reg_i(st[6]), .input_voltage_reg_i(st[5]),
    .output_voltage_reg_i(st[4]), .power_good_i(st[3]), .second_input_present_i(st[2]),
    .first_input_present_i(st[1]), .bus_input_present_i(st[0]), .ts_comparator_i,
    .cool_threshold_sel_o, .warm_threshold_sel_o, .otg_hot_limit_sel_o, .otg_cold_limit_sel_o,
    .thermistor_bypass_o, .cool_threshold_permille_o, .warm_threshold_permille_o,
    .otg_hot_limit_c_o, .otg_hot_check_en_o(), .otg_cold_limit_c_o(), .ts_status_o,
    .charge_temp_ok_o, .otg_temp_ok_o, .optimized_current_limit_o, .charger_condition_flags_o);
  ////////////////////////////////////////////////////////////////////////////////
  // shared helpers
  task automatic cyc(input int n = 1);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr_i = a;
    reg_wdata_i = d;
    reg_wr_i = 1;
    cyc();
    reg_wr_i = 0;
    cyc();
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] exp);
    reg_addr_i = a;
    reg_rd_i = 1;
    cyc();
    reg_rd_i = 0;
    chk({15'h0, reg_rd_ack_o}, 16'h0001);
    chk(reg_rdata_o, exp);
    cyc();
  endtask
  task automatic report_and_stop;
    if (error_cnt == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic t_reset_values;
    rd(`THERM_CFG_OFFSET, 16'h0054);
    rd(`ILIM_OFFSET, 16'h0000);
    rd(`FLAGS_OFFSET, 16'h0000);
  endtask
  task automatic t_config_codes;
    logic [9:0] cp [4] = '{`COOL_PM_0, `COOL_PM_1, `COOL_PM_2, `COOL_PM_3};
    logic [9:0] wp [4] = '{`WARM_PM_0, `WARM_PM_1, `WARM_PM_2, `WARM_PM_3};
    logic [7:0] hp [4] = '{`OTG_HOT_C_0, `OTG_HOT_C_1, `OTG_HOT_C_2, `OTG_HOT_C_2};
    logic [1:0] c;
    logic [7:0] d;
    for (int i = 0; i < 4; i++)
    begin
      c = i;
      d = {c, ~c, c, c[0], c[1]};
      wr(`THERM_CFG_OFFSET, d);
      chk({8'h0, cool_threshold_sel_o, warm_threshold_sel_o, otg_hot_limit_sel_o,
        otg_cold_limit_sel_o, thermistor_bypass_o}, {8'h0, d});
      chk({6'h0, cool_threshold_permille_o}, {6'h0, cp[c]});
      chk({6'h0, warm_threshold_permille_o}, {6'h0, wp[~c]});
      chk({8'h0, otg_hot_limit_c_o}, {8'h0, hp[c]});
      rd(`THERM_CFG_OFFSET, {8'h0, d});
    end
  endtask
  task automatic t_read_only;
    wr(`ILIM_OFFSET, 8'hFF);
    wr(`FLAGS_OFFSET, 8'hFF);
    wr(8'h20, 8'hFF);
    rd(`ILIM_OFFSET, 16'h0000);
    rd(`FLAGS_OFFSET, 16'h0000);
    rd(8'h20, 16'h0000);
    rd(`THERM_CFG_OFFSET, 16'h00CF);
  endtask
  task automatic t_cfg_resets;
    wr(`THERM_CFG_OFFSET, 8'hAB);
    reg_reset_i = 1;
    cyc();
    reg_reset_i = 0;
    rd(`THERM_CFG_OFFSET, 16'h0054);
    wr(`THERM_CFG_OFFSET, 8'hAB);
    watchdog_expired_i = 1;
    cyc(6);
    rd(`THERM_CFG_OFFSET, 16'h0054);
    rd(`FLAGS_OFFSET, 16'h0020);
    watchdog_expired_i = 0;
    cyc(6);
    rd(`FLAGS_OFFSET, 16'h0000);
  endtask
  task automatic t_current_limit;
    logic [8:0] code [3] = '{9'h005, 9'h00A, 9'h14A};
    logic [8:0] exp [3] = '{9'h00A, 9'h00A, 9'h14A};
    for (int i = 0; i < 3; i++)
    begin
      optimized_current_limit_i = code[i];
      ilim_load_i = 1;
      cyc();
      ilim_load_i = 0;
      rd(`ILIM_OFFSET, {7'h0, exp[i]});
    end
  endtask
  task automatic t_flags;
    logic [7:0] e;
    for (int m = 0; m < 2; m++)
      for (int b = 0; b < 9; b++)
      begin
        otg_mode_i = m;
        st = (b < 8) ? (8'h01 << b) : 8'h00;
        cyc(6);
        e = {m ? st[6] : st[7], m ? st[4] : st[5], 2'b00, st[3:0]};
        rd(`FLAGS_OFFSET, {8'h0, e});
      end
    otg_mode_i = 0;
  endtask
  task automatic t_thermistor;
    ts_comparator_i = 4'hA;
    cyc(6);
    chk({12'h0, ts_status_o}, 16'h000A);
    chk({15'h0, charge_temp_ok_o}, 16'h0000);
    chk({15'h0, otg_temp_ok_o}, 16'h0000);
    wr(`THERM_CFG_OFFSET, 8'h55);
    cyc(2);
    chk({12'h0, ts_status_o}, 16'h0000);
    chk({15'h0, charge_temp_ok_o}, 16'h0001);
    chk({15'h0, otg_temp_ok_o}, 16'h0001);
    ts_comparator_i = 4'h1;
    wr(`THERM_CFG_OFFSET, 8'h5C);
    cyc(6);
    chk({12'h0, ts_status_o}, 16'h0001);
    chk({15'h0, charge_temp_ok_o}, 16'h0000);
    chk({15'h0, otg_temp_ok_o}, 16'h0001);
    wr(`THERM_CFG_OFFSET, 8'h54);
    cyc(2);
    chk({15'h0, otg_temp_ok_o}, 16'h0000);
    ts_comparator_i = 4'h0;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // main sequence and watchdog
  initial
  begin
    cyc(4);
    nrst_i = 1;
    cyc();
    t_reset_values();
    t_config_codes();
    t_read_only();
    t_cfg_resets();
    t_current_limit();
    t_flags();
    t_thermistor();
    report_and_stop();
  end
  initial
  begin
    #40000;
    error_cnt++;
    report_and_stop();
  end
endmodule // charger_thermal_status_regs_bench
